//--- pctc_cfg.svh
// Function
// - power bit 0: 0 powers analog section down, 1 powers it on.
// - power bit 1 at 0 powers digital down, internal clock held high.
// - power bit 1 at 1 restarts internal clock from its high phase.
// - select pin high: power bit 2 stops (0) or starts (1) the crystal.
// - select pin high: divided clock output pin held low.
// - select pin low: crystal always runs, divided clock always driven out.
// - power bits 6..4 pick output clock, 8.192 MHz halving down to 0.064 MHz.
// - monitor select codes 000, 101, 110 put extended port bits 0..4 out.
// - other codes route internal groups; 111 carries sync and block id status.
// - sync flags 1 when synchronised; two id code bits, bit 0 least significant.
// - block id detect flag 1 on success, 0 on failure.
// - serial bits 4,0 drive pin 6: low, descrambled, or pre-descramble data.
// - pin 6 data changes only on rising edge of recovered data clock; here on a core clock edge with the bit strobe.
// - serial bit 1 holds pin 5 low at 0, drives recovered clock at 1.
// - serial bit 2: 0 differential decoding on, 1 bypassed.
// - serial bit 3: 0 descrambles all but block id bits, 1 passes through.
// - serial bits 6,5 set delay detector: xnor, delayed, test, xor.
`ifndef PCTC_CFG_SVH
`define PCTC_CFG_SVH
// register offsets on the parallel port
`define PCTC_ADDR_PWR        6'h31
`define PCTC_ADDR_MON        6'h32
`define PCTC_ADDR_SER        6'h33
// reset values and implemented-bit masks
`define PCTC_PWR_RST         8'h00
`define PCTC_MON_RST         8'h00
`define PCTC_SER_RST         8'h00
`define PCTC_PWR_MASK        8'h77
`define PCTC_MON_MASK        8'he0
`define PCTC_SER_MASK        8'h7f
// power register fields
`define PCTC_PWR_ANA         0
`define PCTC_PWR_DIG         1
`define PCTC_PWR_OSC         2
`define PCTC_PWR_DIV_LO      4
`define PCTC_PWR_DIV_HI      6
// monitor select field
`define PCTC_MON_SEL_LO      5
`define PCTC_MON_SEL_HI      7
// serial control fields
`define PCTC_SER_POST        0
`define PCTC_SER_CLK         1
`define PCTC_SER_NODIFF      2
`define PCTC_SER_NODESCR     3
`define PCTC_SER_PRE         4
`define PCTC_SER_DLY_LO      5
`define PCTC_SER_DLY_HI      6
// descrambler shift register
`define PCTC_DESCR_SEED      9'h1ff
`define PCTC_DESCR_TAP       4
// analog settling time, for reference by software timing
`define PCTC_ANA_SETTLE_MS   5
`define PCTC_CLK_MHZ         100
`endif

//--- pctc_pkg.sv
package pctc_pkg;
    // monitor pin 0..4 source selection
    typedef enum logic [2:0] {
        PCTC_MON_PORT0     = 3'h0,
        PCTC_MON_GRP_A     = 3'h1,
        PCTC_MON_GRP_B     = 3'h2,
        PCTC_MON_GRP_C     = 3'h3,
        PCTC_MON_GRP_D     = 3'h4,
        PCTC_MON_PORT1     = 3'h5,
        PCTC_MON_PORT2     = 3'h6,
        PCTC_MON_SYNC_STAT = 3'h7
    } pctc_mon_sel_t;
    // delay detector combining mode
    typedef enum logic [1:0] {
        PCTC_DLY_XNOR_COMBINE = 2'h0,
        PCTC_DLY_THROUGH      = 2'h1,
        PCTC_DLY_TEST_COMBINE = 2'h2,
        PCTC_DLY_XOR_COMBINE  = 2'h3
    } pctc_dly_mode_t;
endpackage : pctc_pkg

//--- pctc_top.sv
`timescale 1ns/1ps
`include "pctc_cfg.svh"
module pctc_top
    import pctc_pkg::*;
(
    // clock and reset
    input  wire logic       CORE_CLK_I,
    input  wire logic       SYS_RST_I,
    // parallel register port (write only)
    input  wire logic       CS_N_I,
    input  wire logic       WR_N_I,
    input  wire logic [5:0] ADDR_I,
    input  wire logic [7:0] DATA_I,
    // oscillator pins
    input  wire logic       OSC_OUTPUT_SELECT_PIN_I,
    input  wire logic       CRYSTAL_IN_PIN_I,
    output logic            CRYSTAL_RUN_O,
    output logic            DIVIDED_CLOCK_OUT_PIN_O,
    // power control
    output logic            ANALOG_POWER_ON_O,
    output logic            DIGITAL_POWER_ON_O,
    output logic            DIGITAL_CLK_O,
    // internal sources for the monitor pins
    input  wire logic [4:0] EXT_PORT_I,
    input  wire logic [4:0] MON_GRP_A_I,
    input  wire logic [4:0] MON_GRP_B_I,
    input  wire logic [4:0] MON_GRP_C_I,
    input  wire logic [4:0] MON_GRP_D_I,
    input  wire logic       FRAME_SYNC_FLAG_I,
    input  wire logic       BLOCK_SYNC_FLAG_I,
    input  wire logic       BLOCK_ID_CODE_LSB_I,
    input  wire logic       BLOCK_ID_CODE_MSB_I,
    input  wire logic       BLOCK_ID_DETECT_FLAG_I,
    // serial receive path
    input  wire logic       RECOVERED_DATA_CLOCK_I,
    input  wire logic       RX_BIT_I,
    input  wire logic       RX_BIT_STB_I,
    input  wire logic       BLOCK_ID_ACTIVE_I,
    // monitor pins
    output logic [4:0]      MONITOR_PIN_O,
    output logic            MONITOR_PIN_5_O,
    output logic            MONITOR_PIN_6_O
);

    // synchroniser stages for the asynchronous pins
    logic [1:0] cs_n_sync_reg;
    logic [1:0] wr_n_sync_reg;
    logic [5:0] addr_s1_reg;
    logic [5:0] addr_s2_reg;
    logic [7:0] data_s1_reg;
    logic [7:0] data_s2_reg;
    logic [1:0] osc_sel_sync_reg;
    logic [1:0] xtal_sync_reg;
    logic       wr_n_prev_reg;
    logic       xtal_prev_reg;

    // control registers
    logic [7:0] pwr_reg;
    logic [7:0] mon_reg;
    logic [7:0] ser_reg;

    // clock generation state
    logic [6:0] div_cnt_reg;
    logic       dig_clk_reg;
    logic       divided_clock_out_pin_reg;
    logic       divided_clock_out_pin_next;
    logic       crun_reg;
    logic       crun_next;

    // serial path state
    logic       prev_raw_reg;
    logic       prev_det_reg;
    logic [8:0] lfsr_reg;
    logic       pin6_reg;
    logic       pin6_next;
    logic [4:0] mon_out_reg;
    logic [4:0] mon_out_next;

    // decoded write strobes
    logic       wr_strobe;
    logic       wr_pwr;
    logic       wr_mon;
    logic       wr_ser;

    // decoded fields
    logic           osc_sel_high;
    logic [2:0]     div_sel;
    pctc_mon_sel_t  mon_sel;
    pctc_dly_mode_t dly_mode;

    // serial path combinational nets
    logic       det_bit;
    logic       dec_bit;
    logic       descr_bit;
    logic       lfsr_fb;
    logic       xtal_rise;

    // two-flop synchronisers for the port, oscillator select and crystal pin inputs
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cs_n_sync_reg    <= 2'h3;
            wr_n_sync_reg    <= 2'h3;
            addr_s1_reg      <= 6'h00;
            addr_s2_reg      <= 6'h00;
            data_s1_reg      <= 8'h00;
            data_s2_reg      <= 8'h00;
            osc_sel_sync_reg <= 2'h0;
            xtal_sync_reg    <= 2'h0;
        end else begin
            cs_n_sync_reg    <= {cs_n_sync_reg[0], CS_N_I};
            wr_n_sync_reg    <= {wr_n_sync_reg[0], WR_N_I};
            addr_s1_reg      <= ADDR_I;
            addr_s2_reg      <= addr_s1_reg;
            data_s1_reg      <= DATA_I;
            data_s2_reg      <= data_s1_reg;
            osc_sel_sync_reg <= {osc_sel_sync_reg[0], OSC_OUTPUT_SELECT_PIN_I};
            xtal_sync_reg    <= {xtal_sync_reg[0], CRYSTAL_IN_PIN_I};
        end
    end

    // edge history on the synchronised levels
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            wr_n_prev_reg <= 1'b1;
            xtal_prev_reg <= 1'b0;
        end else begin
            wr_n_prev_reg <= wr_n_sync_reg[1];
            xtal_prev_reg <= xtal_sync_reg[1];
        end
    end

    // write taken on the rising edge of the write strobe with chip select low
    assign wr_strobe = wr_n_sync_reg[1] & ~wr_n_prev_reg & ~cs_n_sync_reg[1];
    assign wr_pwr    = wr_strobe & (addr_s2_reg == `PCTC_ADDR_PWR);
    assign wr_mon    = wr_strobe & (addr_s2_reg == `PCTC_ADDR_MON);
    assign wr_ser    = wr_strobe & (addr_s2_reg == `PCTC_ADDR_SER);

    // write-only registers, unimplemented bits kept zero
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pwr_reg <= `PCTC_PWR_RST;
            mon_reg <= `PCTC_MON_RST;
            ser_reg <= `PCTC_SER_RST;
        end else begin
            if (wr_pwr) begin
                pwr_reg <= data_s2_reg & `PCTC_PWR_MASK;
            end
            if (wr_mon) begin
                mon_reg <= data_s2_reg & `PCTC_MON_MASK;
            end
            if (wr_ser) begin
                ser_reg <= data_s2_reg & `PCTC_SER_MASK;
            end
        end
    end

    // field decode
    assign osc_sel_high = osc_sel_sync_reg[1];
    assign div_sel      = pwr_reg[`PCTC_PWR_DIV_HI:`PCTC_PWR_DIV_LO];
    assign mon_sel      = pctc_mon_sel_t'(mon_reg[`PCTC_MON_SEL_HI:`PCTC_MON_SEL_LO]);
    assign dly_mode     = pctc_dly_mode_t'(ser_reg[`PCTC_SER_DLY_HI:`PCTC_SER_DLY_LO]);

    // power section enables
    assign ANALOG_POWER_ON_O  = pwr_reg[`PCTC_PWR_ANA];
    assign DIGITAL_POWER_ON_O = pwr_reg[`PCTC_PWR_DIG];

    // internal clock: toggles while on, parked high while off
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            dig_clk_reg <= 1'b1;
        end else if (pwr_reg[`PCTC_PWR_DIG]) begin
            dig_clk_reg <= ~dig_clk_reg;
        end else begin
            dig_clk_reg <= 1'b1;
        end
    end
    assign DIGITAL_CLK_O = dig_clk_reg;

    // crystal runs always with select low, else under software control
    assign crun_next = ~osc_sel_high | pwr_reg[`PCTC_PWR_OSC];

    // crystal run request leaves on a flop, running while the select sync is clear
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            crun_reg <= 1'b1;
        end else begin
            crun_reg <= crun_next;
        end
    end
    assign CRYSTAL_RUN_O = crun_reg;

    // synchronous count of crystal rising edges forms the divider taps
    assign xtal_rise = xtal_sync_reg[1] & ~xtal_prev_reg;
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            div_cnt_reg <= 7'h00;
        end else if (xtal_rise) begin
            div_cnt_reg <= div_cnt_reg + 7'h01;
        end
    end

    // divider select: code 0 passes the crystal, each step halves it
    always_comb begin
        divided_clock_out_pin_next = 1'b0;
        if (osc_sel_high) begin
            divided_clock_out_pin_next = 1'b0;
        end else if (div_sel == 3'h0) begin
            divided_clock_out_pin_next = xtal_sync_reg[1];
        end else begin
            divided_clock_out_pin_next = div_cnt_reg[div_sel - 3'h1];
        end
    end

    // divided clock leaves on a flop
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            divided_clock_out_pin_reg <= 1'b0;
        end else begin
            divided_clock_out_pin_reg <= divided_clock_out_pin_next;
        end
    end
    assign DIVIDED_CLOCK_OUT_PIN_O = divided_clock_out_pin_reg;

    // monitor pins 0..4 source selection
    always_comb begin
        mon_out_next = 5'h00;
        case (mon_sel)
            PCTC_MON_PORT0: begin
                mon_out_next = EXT_PORT_I;
            end
            PCTC_MON_PORT1: begin
                mon_out_next = EXT_PORT_I;
            end
            PCTC_MON_PORT2: begin
                mon_out_next = EXT_PORT_I;
            end
            PCTC_MON_GRP_A: begin
                mon_out_next = MON_GRP_A_I;
            end
            PCTC_MON_GRP_B: begin
                mon_out_next = MON_GRP_B_I;
            end
            PCTC_MON_GRP_C: begin
                mon_out_next = MON_GRP_C_I;
            end
            PCTC_MON_GRP_D: begin
                mon_out_next = MON_GRP_D_I;
            end
            PCTC_MON_SYNC_STAT: begin
                // sync_status_monitor_group: status flags in fixed pin order
                mon_out_next = {BLOCK_ID_DETECT_FLAG_I,
                                BLOCK_ID_CODE_MSB_I,
                                BLOCK_ID_CODE_LSB_I,
                                BLOCK_SYNC_FLAG_I,
                                FRAME_SYNC_FLAG_I};
            end
            default: begin
                mon_out_next = 5'h00;
            end
        endcase
    end

    // monitor pins 0..4 registered
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            mon_out_reg <= 5'h00;
        end else begin
            mon_out_reg <= mon_out_next;
        end
    end
    assign MONITOR_PIN_O = mon_out_reg;

    // pin 5: recovered data clock or low
    assign MONITOR_PIN_5_O = ser_reg[`PCTC_SER_CLK] & RECOVERED_DATA_CLOCK_I;

    // delay detector against the bit one period earlier
    always_comb begin
        det_bit = 1'b0;
        case (dly_mode)
            PCTC_DLY_XNOR_COMBINE: begin
                det_bit = ~(RX_BIT_I ^ prev_raw_reg);
            end
            PCTC_DLY_THROUGH: begin
                det_bit = prev_raw_reg;
            end
            PCTC_DLY_TEST_COMBINE: begin
                det_bit = RX_BIT_I;
            end
            PCTC_DLY_XOR_COMBINE: begin
                det_bit = RX_BIT_I ^ prev_raw_reg;
            end
            default: begin
                det_bit = 1'b0;
            end
        endcase
    end

    // differential decoding, then descrambling outside block id bits
    assign dec_bit   = ser_reg[`PCTC_SER_NODIFF] ? det_bit : (det_bit ^ prev_det_reg);
    assign lfsr_fb   = lfsr_reg[8] ^ lfsr_reg[`PCTC_DESCR_TAP - 1];
    assign descr_bit = (ser_reg[`PCTC_SER_NODESCR] | BLOCK_ID_ACTIVE_I) ?
                       dec_bit : (dec_bit ^ lfsr_reg[8]);

    // serial history and descrambler sequence, advanced once per bit
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            prev_raw_reg <= 1'b0;
            prev_det_reg <= 1'b0;
            lfsr_reg     <= `PCTC_DESCR_SEED;
        end else if (RX_BIT_STB_I) begin
            prev_raw_reg <= RX_BIT_I;
            prev_det_reg <= det_bit;
            if (BLOCK_ID_ACTIVE_I) begin
                lfsr_reg <= `PCTC_DESCR_SEED;
            end else begin
                lfsr_reg <= {lfsr_reg[7:0], lfsr_fb};
            end
        end
    end

    // pin 6 source: low, descrambled, or before descrambling
    always_comb begin
        pin6_next = 1'b0;
        if (ser_reg[`PCTC_SER_PRE]) begin
            pin6_next = dec_bit;
        end else if (ser_reg[`PCTC_SER_POST]) begin
            pin6_next = descr_bit;
        end else begin
            pin6_next = 1'b0;
        end
    end

    // pin 6 updates only with the bit strobe at the clock's rising edge
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pin6_reg <= 1'b0;
        end else if (RX_BIT_STB_I) begin
            pin6_reg <= pin6_next;
        end
    end
    assign MONITOR_PIN_6_O = pin6_reg;

endmodule : pctc_top

//--- pctc_top_assertions.sv
`timescale 1ns/1ps
module pctc_checker (
    // clock, reset and strobes
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CS_N_I,
    input wire logic WR_N_I,
    input wire logic OSC_OUTPUT_SELECT_PIN_I,
    input wire logic RECOVERED_DATA_CLOCK_I,
    input wire logic RX_BIT_STB_I,
    // watched outputs
    input wire logic CRYSTAL_RUN_O,
    input wire logic DIVIDED_CLOCK_OUT_PIN_O,
    input wire logic ANALOG_POWER_ON_O,
    input wire logic DIGITAL_POWER_ON_O,
    input wire logic DIGITAL_CLK_O,
    input wire logic MONITOR_PIN_5_O,
    input wire logic MONITOR_PIN_6_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // power bits move only after a selected write strobe
    a_ana_needs_write: assert property ($changed(ANALOG_POWER_ON_O) |->
        $past(WR_N_I, 2) && !$past(WR_N_I, 5) && !$past(CS_N_I, 3)) else $error("analog power moved alone");
    a_dig_needs_write: assert property ($changed(DIGITAL_POWER_ON_O) |->
        $past(WR_N_I, 2) && !$past(WR_N_I, 5) && !$past(CS_N_I, 3)) else $error("digital power moved alone");
    // internal clock held high while off, toggling while on
    a_dig_clk_held: assert property (!$past(DIGITAL_POWER_ON_O) |-> DIGITAL_CLK_O)
        else $error("internal clock not high while off");
    a_dig_clk_runs: assert property ($past(DIGITAL_POWER_ON_O, 2) && $past(DIGITAL_POWER_ON_O) &&
        DIGITAL_POWER_ON_O |-> DIGITAL_CLK_O != $past(DIGITAL_CLK_O)) else $error("internal clock stuck");
    // oscillator select pin
    a_divided_clock_out_pin_held_low: assert property (OSC_OUTPUT_SELECT_PIN_I [*5] |-> !DIVIDED_CLOCK_OUT_PIN_O)
        else $error("divided clock not low");
    a_crystal_always_on: assert property (!OSC_OUTPUT_SELECT_PIN_I [*5] |-> CRYSTAL_RUN_O)
        else $error("crystal stopped");
    // serial monitor pins
    a_pin5_gated: assert property (!RECOVERED_DATA_CLOCK_I |-> !MONITOR_PIN_5_O)
        else $error("pin 5 high without clock");
    a_pin6_on_strobe: assert property (!$past(RX_BIT_STB_I) |-> $stable(MONITOR_PIN_6_O))
        else $error("pin 6 moved off the clock edge");
endmodule : pctc_checker

bind pctc_top pctc_checker u_pctc_checker (
    .CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .CS_N_I(CS_N_I), .WR_N_I(WR_N_I),
    .OSC_OUTPUT_SELECT_PIN_I(OSC_OUTPUT_SELECT_PIN_I), .RECOVERED_DATA_CLOCK_I(RECOVERED_DATA_CLOCK_I),
    .RX_BIT_STB_I(RX_BIT_STB_I), .CRYSTAL_RUN_O(CRYSTAL_RUN_O), .DIVIDED_CLOCK_OUT_PIN_O(DIVIDED_CLOCK_OUT_PIN_O),
    .ANALOG_POWER_ON_O(ANALOG_POWER_ON_O), .DIGITAL_POWER_ON_O(DIGITAL_POWER_ON_O), .DIGITAL_CLK_O(DIGITAL_CLK_O),
    .MONITOR_PIN_5_O(MONITOR_PIN_5_O), .MONITOR_PIN_6_O(MONITOR_PIN_6_O));

//--- pctc_top_tb_top.sv
`timescale 1ns/1ps
module pctc_top_tb_top;
    // bench stimulus and observed outputs
    logic       clk = 1'b0, rst = 1'b1, cs_n = 1'b1, wr_n = 1'b1, sel = 1'b0;
    logic       rclk = 1'b1, rxb = 1'b0, stb = 1'b0, bid = 1'b0, pr = 1'b0, pd = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] data = 8'h00, xcnt = 8'h00;
    logic [4:0] ext = 5'h16, ga = 5'h03, gb = 5'h0c, gc = 5'h11, gd = 5'h1e, flg = 5'h0a;
    logic [8:0] lf = 9'h1ff;
    logic       crun, divided_clock_out_pin, ana, dig, dclk, p5, p6;
    logic [4:0] mon;
    int         failures = 0, checks = 0;

    pctc_top u_pctc_top (
        .CORE_CLK_I(clk), .SYS_RST_I(rst), .CS_N_I(cs_n), .WR_N_I(wr_n), .ADDR_I(addr), .DATA_I(data),
        .OSC_OUTPUT_SELECT_PIN_I(sel), .CRYSTAL_IN_PIN_I(xcnt[2]), .CRYSTAL_RUN_O(crun),
        .DIVIDED_CLOCK_OUT_PIN_O(divided_clock_out_pin), .ANALOG_POWER_ON_O(ana), .DIGITAL_POWER_ON_O(dig), .DIGITAL_CLK_O(dclk),
        .EXT_PORT_I(ext), .MON_GRP_A_I(ga), .MON_GRP_B_I(gb), .MON_GRP_C_I(gc), .MON_GRP_D_I(gd),
        .FRAME_SYNC_FLAG_I(flg[0]), .BLOCK_SYNC_FLAG_I(flg[1]), .BLOCK_ID_CODE_LSB_I(flg[2]),
        .BLOCK_ID_CODE_MSB_I(flg[3]), .BLOCK_ID_DETECT_FLAG_I(flg[4]), .RECOVERED_DATA_CLOCK_I(rclk),
        .RX_BIT_I(rxb), .RX_BIT_STB_I(stb), .BLOCK_ID_ACTIVE_I(bid), .MONITOR_PIN_O(mon),
        .MONITOR_PIN_5_O(p5), .MONITOR_PIN_6_O(p6));

    // core clock and a crystal eight cycles long
    always #5 clk = ~clk;
    always @(posedge clk) #1 xcnt <= xcnt + 8'h01;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    // one write on the parallel port, strobe taken at write rising edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        addr = a;
        data = d;
        cs_n = 1'b0;
        cyc(1);
        wr_n = 1'b0;
        cyc(4);
        wr_n = 1'b1;
        cyc(3);
        cs_n = 1'b1;
        cyc(6);
    endtask : wr

    task automatic t_reset();
        chk({ana, dig, dclk, p5, p6}, 5'b00100);
        chk(mon, ext);
        $display("test reset done");
    endtask : t_reset

    task automatic t_power();
        logic d0;
        wr(6'h30, 8'hff);
        chk({ana, dig}, 2'b00);
        wr(6'h31, 8'h01);
        chk({ana, dig}, 2'b10);
        wr(6'h31, 8'h03);
        d0 = dclk;
        cyc(1);
        chk({dig, dclk}, {1'b1, ~d0});
        wr(6'h31, 8'h01);
        cyc(3);
        chk({ana, dig, dclk}, 3'b101);
        $display("test power done");
    endtask : t_power

    task automatic t_monitor();
        logic [4:0] tbl [8];
        tbl = '{ext, ga, gb, gc, gd, ext, ext, flg};
        for (int c = 0; c < 8; c++) begin
            wr(6'h32, {c[2:0], 5'h00});
            chk(mon, tbl[c]);
        end
        flg = 5'h13;
        cyc(2);
        chk(mon, 5'h13);
        $display("test monitor done");
    endtask : t_monitor

    // cycles between two divided clock rises
    task automatic per(output int p);
        logic v;
        int   r;
        r = -1;
        p = 0;
        v = divided_clock_out_pin;
        for (int k = 0; k < 300; k++) begin
            cyc(1);
            if (divided_clock_out_pin === 1'b1 && v === 1'b0) begin
                if (r >= 0) begin
                    p = k - r;
                    break;
                end
                r = k;
            end
            v = divided_clock_out_pin;
        end
    endtask : per

    task automatic t_osc();
        int p;
        sel = 1'b1;
        wr(6'h31, 8'h04);
        chk(crun, 1'b1);
        for (int i = 0; i < 8; i++) begin
            cyc(5);
            chk(divided_clock_out_pin, 1'b0);
        end
        wr(6'h31, 8'h00);
        chk({crun, divided_clock_out_pin}, 2'b00);
        sel = 1'b0;
        cyc(4);
        chk(crun, 1'b1);
        for (int n = 0; n < 4; n++) begin
            wr(6'h31, {1'b0, n[2:0], 4'h0});
            per(p);
            chk(p[7:0], 8'h08 << n);
        end
        $display("test oscillator done");
    endtask : t_osc

    // one received bit with the recovered clock, modelled and checked on pin 6
    task automatic sb(input logic [7:0] cfg, input logic b, input logic judge);
        logic det, dec, post;
        rxb = b;
        rclk = 1'b1;
        stb = 1'b1;
        cyc(1);
        stb = 1'b0;
        cyc(3);
        rclk = 1'b0;
        cyc(2);
        case (cfg[6:5])
            2'b00: det = ~(b ^ pr);
            2'b01: det = pr;
            2'b10: det = b;
            default: det = b ^ pr;
        endcase
        dec = cfg[2] ? det : det ^ pd;
        // descrambler: 9-bit sequence, seed all ones, taps 8 and 3, reseeded on block id bits
        post = (cfg[3] | bid) ? dec : dec ^ lf[8];
        lf = bid ? 9'h1ff : {lf[7:0], lf[8] ^ lf[3]};
        pr = b;
        pd = det;
        if (judge) chk(p6, cfg[4] ? dec : (cfg[0] & post));
    endtask : sb

    task automatic t_serial();
        logic [7:0] cfgs [9];
        cfgs = '{8'h14, 8'h34, 8'h54, 8'h74, 8'h50, 8'h4d, 8'h45, 8'h05, 8'h00};
        wr(6'h33, 8'h02);
        chk(p5, 1'b1);
        rclk = 1'b0;
        cyc(1);
        chk(p5, 1'b0);
        rclk = 1'b1;
        cyc(1);
        wr(6'h33, 8'h00);
        chk(p5, 1'b0);
        sb(8'h00, 1'b1, 1'b0);
        sb(8'h00, 1'b0, 1'b0);
        for (int i = 0; i < 9; i++) begin
            wr(6'h33, cfgs[i]);
            bid = (cfgs[i] == 8'h45);
            for (int j = 0; j < 8; j++) sb(cfgs[i], j[0] ^ j[1], 1'b1);
        end
        bid = 1'b0;
        $display("test serial done");
    endtask : t_serial

    // main sequence
    initial begin
        cyc(12);
        rst = 1'b0;
        cyc(3);
        t_reset();
        t_power();
        t_monitor();
        t_osc();
        t_serial();
        finish_test();
    end

    // watchdog against a hang
    initial begin
        #200000;
        failures++;
        finish_test();
    end
endmodule : pctc_top_tb_top
